// file: tsod_checker.sv
// Port assertions for the step option decoder
`timescale 1ns/10ps
`default_nettype none
module tsod_checker (input wire logic clk_i, reset_n_i, step_valid_i, step_done_o, waiting_o,
  input wire logic [3:0] step_cmd_i, seq_irq_o, input wire logic [4:0] step_opt_i,
  input wire logic [15:0] event_i, input wire logic [7:0] step_ptr_o,
  input wire logic [31:0] trig_out_o);
  wire [3:0] o = step_opt_i[3:0], c = step_cmd_i;
  wire tk = step_valid_i && !step_done_o, hit = event_i[o], w = tk && c[3:1] == 3'h2;
  wire wh = w && !c[0];
  // Reserved picks still retire, only without a pulse
  wire rs = tk && !(c inside {4'h4, 4'h5, 4'h7, 4'hA}) || tk && c == 4'h7 && o > 4'h3
    || w && o inside {4'h5, 4'h6};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  pwm_sel_a: assert property (wh && o < 5 && o != 1 |-> waiting_o != hit) else $error("pwm");
  sync_sel_a: assert property (w && o == 1 |-> waiting_o == (hit == c[0])) else $error("sync");
  late_sel_a: assert property (wh && o > 6 |=> step_done_o == $past(hit)) else $error("late");
  irq_pick_a: assert property (tk && c == 4'h7 && o < 4 |=> seq_irq_o == 4'h1 << $past(o))
    else $error("irq");
  rsvd_nop_a: assert property (rs |=> step_done_o && !{seq_irq_o, trig_out_o}) else $error("nop");
  trig_pick_a: assert property (tk && c == 4'hA |=> trig_out_o == 32'h1 << $past(step_opt_i))
    else $error("trig");
  ptr_step_a: assert property (step_done_o |-> step_ptr_o == $past(step_ptr_o) + 8'h1)
    else $error("ptr");
endmodule // tsod_checker
bind tsod_step_decode tsod_checker chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .step_valid_i(step_valid_i), .step_done_o(step_done_o), .waiting_o(waiting_o),
  .step_cmd_i(step_cmd_i), .seq_irq_o(seq_irq_o), .step_opt_i(step_opt_i), .event_i(event_i),
  .step_ptr_o(step_ptr_o), .trig_out_o(trig_out_o));
`default_nettype wire

// file: tsod_event_model.sv
// Event source model: the picked event flips after a delay
`timescale 1ns/10ps
`default_nettype none
module tsod_event_model (input wire logic clk_i, go_i, pol_i, input wire logic [3:0] idx_i,
  output logic [15:0] event_o);
  logic [3:0] cnt = 4'h0;
  always @(posedge clk_i) cnt <= go_i ? (pol_i ? 4'h0 : 4'h3) : cnt - 4'(cnt != 4'h0);
  // Other events sit at the met level so a wrong pick retires early
  assign event_o = {16{pol_i}} ^ (cnt == 4'h0 && !go_i ? 16'h1 << idx_i : ~(16'h1 << idx_i));
endmodule // tsod_event_model
`default_nettype wire

// file: tsod_pkg.sv
// Package with command, option and event index constants for the step option decoder
package tsod_pkg;
  localparam int unsigned CMD_W = 4;
  localparam int unsigned OPT_W = 5;
  localparam int unsigned EVT_N = 16;
  localparam int unsigned IRQ_N = 4;
  localparam int unsigned TRIG_N = 32;
  // Step command codes (upper nibble of a step)
  localparam logic [3:0] CMD_WAIT_HIGH = 4'h4;
  localparam logic [3:0] CMD_WAIT_LOW = 4'h5;
  localparam logic [3:0] CMD_RAISE_IRQ = 4'h7;
  localparam logic [3:0] CMD_PULSE_TRIG = 4'hA;
  // Wait option codes
  localparam logic [3:0] OPT_PWM_SPECIAL = 4'h0;
  localparam logic [3:0] OPT_PWM_MASTER_SYNC = 4'h1;
  localparam logic [3:0] OPT_PWM_GEN_ONE = 4'h2;
  localparam logic [3:0] OPT_PWM_GEN_THREE = 4'h4;
  localparam logic [3:0] OPT_RSVD_A = 4'h5;
  localparam logic [3:0] OPT_RSVD_B = 4'h6;
  localparam logic [3:0] OPT_OUT_CMP_ONE = 4'h7;
  localparam logic [3:0] OPT_OUT_CMP_TWO = 4'h8;
  localparam logic [3:0] OPT_IN_CAP_ONE = 4'h9;
  localparam logic [3:0] OPT_CMP_ONE = 4'hA;
  localparam logic [3:0] OPT_CMP_FOUR = 4'hD;
  localparam logic [3:0] OPT_ADC_DONE = 4'hE;
  localparam logic [3:0] OPT_EXT_IRQ_TWO = 4'hF;
  // Highest interrupt option that is not reserved
  localparam logic [3:0] OPT_IRQ_LAST = 4'h3;
  // Reset values
  localparam logic [7:0] STEP_PTR_RST = 8'h00;
endpackage

// file: tsod_step_decode.sv
// Step option decoder of the trigger sequencer
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Wait options 0, 2, 3, 4 pick PWM special event and generators one to three.
// - Wait option 1 picks the PWM master time base sync output.
// - Wait options 7 to 15 pick compares, capture, comparators, ADC done, irq two.
// - Interrupt options 0 to 3 and 16 to 19 raise sequencer interrupts 0 to 3; others reserved.
// - Reserved commands and options execute as a step with no effect.
// - Trigger option 0 to 31 pulses one of thirty-two trigger outputs.
module tsod_step_decode #(
  parameter int unsigned PTR_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Step from the queue
  input wire logic step_valid_i,
  input wire logic [3:0] step_cmd_i,
  input wire logic [4:0] step_opt_i,
  // Event sources, index equals wait option code
  input wire logic [tsod_pkg::EVT_N-1:0] event_i,
  // Step control
  output logic step_done_o,
  output logic waiting_o,
  output logic [PTR_W-1:0] step_ptr_o,
  // Outputs to peripherals
  output logic [tsod_pkg::IRQ_N-1:0] seq_irq_o,
  output logic [tsod_pkg::TRIG_N-1:0] trig_out_o
);

  // Event inputs come from logic on this same clock, so they pass no synchroniser

  // Kinds of step that this decoder acts on
  typedef enum {
    kind_wait,
    kind_irq,
    kind_trig,
    kind_nop
  } tsod_kind_type;

  // Decoded command
  tsod_kind_type step_kind;
  logic take;
  logic cmd_wait;
  logic cmd_wait_high;
  logic cmd_irq;
  logic cmd_trig;

  // Decoded option
  logic opt_wait_used;
  logic opt_irq_used;
  logic [tsod_pkg::EVT_N-1:0] evt_pick;
  logic [tsod_pkg::IRQ_N-1:0] irq_hit;
  logic [tsod_pkg::TRIG_N-1:0] trig_hit;

  // Wait condition and retire
  logic sel_level;
  logic cond_met;
  logic retire;

  // Step control state
  logic [PTR_W-1:0] ptr_reg;
  logic [PTR_W-1:0] ptr_next;
  logic done_reg;
  logic done_next;

  // Pulse state
  logic [tsod_pkg::IRQ_N-1:0] irq_reg;
  logic [tsod_pkg::IRQ_N-1:0] irq_next;
  logic [tsod_pkg::TRIG_N-1:0] trig_reg;
  logic [tsod_pkg::TRIG_N-1:0] trig_next;

  // Wait options 5 and 6 name no source
  function automatic logic wait_opt_used(input logic [3:0] opt);
    wait_opt_used = (opt != tsod_pkg::OPT_RSVD_A) && (opt != tsod_pkg::OPT_RSVD_B);
  endfunction

  // Interrupt options above the last one are reserved
  function automatic logic irq_opt_used(input logic [3:0] opt);
    irq_opt_used = opt <= tsod_pkg::OPT_IRQ_LAST;
  endfunction

  // Option match, shared by the three pickers below
  function automatic logic opt_is(input logic [4:0] opt, input logic [4:0] idx);
    opt_is = opt == idx;
  endfunction

  // Source picker: the wait option code is the index of the awaited source
  for (genvar e = 0; e < tsod_pkg::EVT_N; e++) begin : g_evt
    assign evt_pick[e] = opt_is({1'b0, step_opt_i[3:0]}, 5'(e)) && event_i[e];
  end

  // Interrupt line picker, on the low option nibble only
  for (genvar q = 0; q < tsod_pkg::IRQ_N; q++) begin : g_irq_hit
    assign irq_hit[q] = opt_is({1'b0, step_opt_i[3:0]}, 5'(q));
  end

  // Trigger line picker, on all five option bits
  for (genvar t = 0; t < tsod_pkg::TRIG_N; t++) begin : g_trig_hit
    assign trig_hit[t] = opt_is(step_opt_i, 5'(t));
  end

  // Command decode; unknown codes fall to the no-op kind
  always_comb begin
    case (step_cmd_i)
      tsod_pkg::CMD_WAIT_HIGH: begin
        step_kind = kind_wait;
      end
      tsod_pkg::CMD_WAIT_LOW: begin
        step_kind = kind_wait;
      end
      tsod_pkg::CMD_RAISE_IRQ: begin
        step_kind = kind_irq;
      end
      tsod_pkg::CMD_PULSE_TRIG: begin
        step_kind = kind_trig;
      end
      default: begin
        step_kind = kind_nop;
      end
    endcase
  end

  // A step is taken once; the done flag masks the repeat
  always_comb begin
    take = step_valid_i && !done_reg;
    cmd_wait = step_kind == kind_wait;
    cmd_wait_high = step_cmd_i == tsod_pkg::CMD_WAIT_HIGH;
    cmd_irq = step_kind == kind_irq;
    cmd_trig = step_kind == kind_trig;
    opt_wait_used = wait_opt_used(step_opt_i[3:0]);
    opt_irq_used = irq_opt_used(step_opt_i[3:0]);
  end

  // Level sampled, not edge: a source already at the level retires at once
  always_comb begin
    sel_level = |evt_pick;
    cond_met = sel_level == cmd_wait_high;
    retire = 1'b0;
    if (take) begin
      case (step_kind)
        kind_wait: begin
          retire = !opt_wait_used || cond_met;
        end
        kind_irq: begin
          retire = 1'b1;
        end
        kind_trig: begin
          retire = 1'b1;
        end
        default: begin
          retire = 1'b1;
        end
      endcase
    end
  end

  // Step control next state
  // Pointer wraps at the top; the queue owns the step range
  always_comb begin
    done_next = retire;
    ptr_next = ptr_reg;
    if (retire) begin
      ptr_next = PTR_W'(ptr_reg + 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_reg <= tsod_pkg::STEP_PTR_RST[PTR_W-1:0];
      done_reg <= 1'b0;
    end else begin
      ptr_reg <= ptr_next;
      done_reg <= done_next;
    end
  end

  // Interrupt pulses last one cycle; reserved options leave them low
  always_comb begin
    irq_next = '0;
    if (take && cmd_irq && opt_irq_used) begin
      irq_next = irq_hit;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_reg <= '0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // Trigger pulses last one cycle
  // Every five-bit code names an output, so none is reserved here
  always_comb begin
    trig_next = '0;
    if (take && cmd_trig) begin
      trig_next = trig_hit;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_reg <= '0;
    end else begin
      trig_reg <= trig_next;
    end
  end

  // The done flag blocks a second execution while the queue swaps in the next step
  assign step_done_o = done_reg;
  assign waiting_o = take && cmd_wait && opt_wait_used && !cond_met;
  assign step_ptr_o = ptr_reg;
  assign seq_irq_o = irq_reg;
  assign trig_out_o = trig_reg;

endmodule // tsod_step_decode
`default_nettype wire

// file: tsod_step_decode_bench.sv
// Self-checking bench for the step option decoder
`timescale 1ns/10ps
`default_nettype none
module tsod_step_decode_bench;
  logic clk_i = 0, reset_n_i = 0, step_valid_i = 0, go = 0, step_done_o, waiting_o;
  logic [3:0] step_cmd_i = 4'h0, seq_irq_o;
  logic [4:0] step_opt_i = 5'h0;
  logic [15:0] event_i;
  logic [7:0] step_ptr_o, ptr = 8'h0;
  logic [31:0] trig_out_o;
  int fail_count = 0, total_checks = 0, cyc = 0, n;
  always #2.5 clk_i = ~clk_i;
  tsod_step_decode dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .step_valid_i(step_valid_i),
    .step_cmd_i(step_cmd_i), .step_opt_i(step_opt_i), .event_i(event_i),
    .step_done_o(step_done_o), .waiting_o(waiting_o), .step_ptr_o(step_ptr_o),
    .seq_irq_o(seq_irq_o), .trig_out_o(trig_out_o));
  tsod_event_model evm (.clk_i, .go_i(go), .pol_i(step_cmd_i[0]), .idx_i(step_opt_i[3:0]),
    .event_o(event_i));
  task chk(string s, logic [47:0] e, g);
    total_checks++;
    if (e !== g) $display("[ERR] %s exp %h got %h", s, e, g);
    fail_count += int'(e !== g);
  endtask
  task step(int c, p, en, ei, et);
    @(posedge clk_i) {step_cmd_i, step_opt_i, step_valid_i, go} <= {c[3:0], p[4:0], 2'h3};
    n = 0;
    do @(posedge clk_i) begin
      go <= 0;
      #1 n++;
      chk("waiting", 48'(c[3:0] inside {4'h4, 4'h5} && n < en - 1), 48'(waiting_o));
    end while (step_done_o !== 1'b1 && n < 9);
    ptr++;
    chk("cycles and pointer", {en[7:0], ptr}, {n[7:0], step_ptr_o});
    chk("pulses", {ei[3:0], et}, {seq_irq_o, trig_out_o});
    @(posedge clk_i) step_valid_i <= 0;
  endtask
  task t_wait;
    for (int i = 0; i < 32; i++) step(4 + i / 16, i % 16, i % 16 inside {5, 6} ? 1 :
      i < 16 ? 5 : 2, 0, 0);
    $display("wait test done");
  endtask
  task t_irq;
    for (int i = 0; i < 16; i++) step(7, i, 1, i < 4 ? 1 << i : 0, 0);
    $display("irq test done");
  endtask
  task t_trig;
    for (int i = 0; i < 32; i++) step(10, i, 1, 0, 1 << i);
    $display("trigger test done");
  endtask
  task t_nop;
    for (int i = 0; i < 16; i++) if (!(i inside {4, 5, 7, 10})) step(i, 9, 1, 0, 0);
    $display("nop test done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i) if (++cyc == 2000) begin fail_count++; results; end
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1;
    t_wait;
    t_irq;
    t_trig;
    t_nop;
    results;
  end
endmodule // tsod_step_decode_bench
`default_nettype wire
